// File: verilog/rsf_pkg.sv
package rsf_pkg;

  // Stream geometry
  localparam int BEAT_W         = 512;
  localparam int HALF_W         = 256;
  localparam int HALF_OFS_W     = 3;
  localparam int DW_OFS_W       = 4;
  localparam int BEAT_DWORDS    = 16;
  localparam int SIDEBAND_W     = 96;
  localparam int SIDEBAND_LOW_W = 80;
  localparam int WORD_W         = 32;
  localparam int STRB_W         = 4;
  localparam int REG_OFS_W      = 8;

  // Sideband field codes
  localparam logic [1:0]          FLAGS_NONE    = 2'h0;
  localparam logic [1:0]          FLAGS_ONE     = 2'h1;
  localparam logic [1:0]          FLAGS_TWO     = 2'h3;
  localparam logic [1:0]          LANE_0_CODE   = 2'h0;
  localparam logic [1:0]          LANE_32_CODE  = 2'h2;
  localparam logic [DW_OFS_W-1:0] OFS_ZERO      = 4'h0;
  localparam logic [DW_OFS_W-1:0] UPPER_DW_BASE = 4'h8;
  localparam logic [HALF_W-1:0]   HALF_ZERO     = '0;
  localparam logic [SIDEBAND_LOW_W-1:0] SIDEBAND_LOW_ZERO = '0;

  // Register map
  localparam logic [REG_OFS_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [REG_OFS_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [REG_OFS_W-1:0] PKTCNT_OFS = 8'h08;
  localparam logic [REG_OFS_W-1:0] BEATCNT_OFS = 8'h0C;
  localparam int   CTRL_STRADDLE_BIT  = 0;
  localparam int   CTRL_CLEAR_BIT     = 1;
  localparam int   STAT_HOLD_BIT      = 0;
  localparam int   STAT_INPKT_BIT     = 1;
  localparam int   STAT_OUTV_BIT      = 2;
  localparam logic CTRL_STRADDLE_RESET = 1'b0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {RSF_EMPTY, RSF_HAVE_LOW} rsf_state_e;
  typedef enum logic [2:0] {RSF_REG_CTRL, RSF_REG_STATUS, RSF_REG_PKTCNT,
                            RSF_REG_BEATCNT, RSF_REG_NONE} rsf_reg_e;

  // One 256-bit half of a beat
  typedef struct packed {
    logic                  present;
    logic                  start;
    logic                  stop;
    logic [HALF_OFS_W-1:0] offset;
  } rsf_half_s;

  // Boundary fields, laid out as sideband bits 95:80
  typedef struct packed {
    logic [DW_OFS_W-1:0] second_end_dword_offset;
    logic [DW_OFS_W-1:0] first_end_dword_offset;
    logic [1:0]          packet_end_flags;
    logic [1:0]          second_start_lane;
    logic [1:0]          first_start_lane;
    logic [1:0]          packet_start_flags;
  } rsf_flags_s;

  typedef struct packed {
    logic [BEAT_W-1:0] data;
    logic              last;
    logic              abort;
    rsf_flags_s        flags;
  } rsf_beat_s;

endpackage

// File: verilog/rsf_flag_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_flag_encoder
(
  // Mode
  input  wire logic           straddle,
  // Beat halves
  input  wire rsf_pkg::rsf_half_s low,
  input  wire rsf_pkg::rsf_half_s up,
  // Encoded fields
  output rsf_pkg::rsf_flags_s flags,
  output logic                last
);
  import rsf_pkg::*;

  logic ls;
  logic us;
  logic le;
  logic ue;

  // Starts and ends present in each half
  assign ls = low.present && low.start;
  assign us = up.present && up.start && straddle;
  assign le = low.present && low.stop;
  assign ue = up.present && up.stop;

  // Field encoding; reserved codes cannot be produced
  always_comb
  begin
    flags = '0;
    flags.packet_start_flags = (ls && us) ? FLAGS_TWO :
                               ((ls || us) ? FLAGS_ONE : FLAGS_NONE);
    flags.first_start_lane   = (!ls && us) ? LANE_32_CODE : LANE_0_CODE;
    flags.second_start_lane  = (ls && us) ? LANE_32_CODE : LANE_0_CODE;
    flags.packet_end_flags   = (le && ue && straddle) ? FLAGS_TWO :
                               ((le || ue) ? FLAGS_ONE : FLAGS_NONE);
    if (le)
    begin
      flags.first_end_dword_offset = {1'b0, low.offset};
    end
    else if (ue)
    begin
      flags.first_end_dword_offset = UPPER_DW_BASE | {1'b0, up.offset};
    end
    if (le && ue && straddle)
    begin
      flags.second_end_dword_offset = UPPER_DW_BASE | {1'b0, up.offset};
    end
  end

  // Any packet ending in the beat raises tlast
  assign last = le || ue;

endmodule
`default_nettype wire

// File: verilog/rsf_stream_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_stream_buffer #(
  parameter int WIDTH = 530,
  parameter int DEPTH = 2
)
(
  // Clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || DEPTH != (1 << PTR_W))
    begin : g_bad_depth
      $error("buffer depth must be a power of two, at least two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  // Handshakes are dead while the enable is low, so no transfer is lost
  assign in_ready  = ce && (count != (PTR_W+1)'(DEPTH));
  assign out_valid = ce && (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage, cleared so the data output is defined from reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce)
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

endmodule
`default_nettype wire

// File: verilog/rsf_framer.sv
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module rsf_framer #(
  parameter int DATA_W = rsf_pkg::BEAT_W,
  parameter int ADDR_W = rsf_pkg::REG_OFS_W
)
(
  // Clock, reset, enable
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  // Half-beat segments from the transaction layer
  input  wire logic                          seg_valid,
  output logic                               seg_ready,
  input  wire logic [rsf_pkg::HALF_W-1:0]    seg_data,
  input  wire logic                          seg_last,
  input  wire logic [rsf_pkg::HALF_OFS_W-1:0] seg_last_offset,
  input  wire logic                          seg_abort,
  // Request stream to user logic
  output logic                               req_valid,
  input  wire logic                          req_ready,
  output logic [rsf_pkg::BEAT_W-1:0]         req_data,
  output logic                               req_last,
  output logic                               req_abort,
  output logic [rsf_pkg::SIDEBAND_W-1:0]     request_stream_sideband,
  // AXI4-Lite write channels
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  input  wire logic [rsf_pkg::WORD_W-1:0]    s_axi_wdata,
  input  wire logic [rsf_pkg::STRB_W-1:0]    s_axi_wstrb,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output logic [1:0]                         s_axi_bresp,
  // AXI4-Lite read channels
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output logic [rsf_pkg::WORD_W-1:0]         s_axi_rdata,
  output logic [1:0]                         s_axi_rresp
);
  import rsf_pkg::*;

  generate
    if (DATA_W != BEAT_W || DATA_W / WORD_W != BEAT_DWORDS)
    begin : g_bad_width
      $error("stream width must be 512 bits, sixteen Dwords");
    end
    if (ADDR_W < REG_OFS_W)
    begin : g_bad_addr
      $error("register address must be at least eight bits");
    end
  endgenerate

  // Register decode, shared by the write and read paths
  function automatic rsf_reg_e reg_decode(input logic [ADDR_W-1:0] addr);
    logic [REG_OFS_W-1:0] ofs;
    ofs = addr[REG_OFS_W-1:0];
    case (ofs)
      CTRL_OFS:    reg_decode = RSF_REG_CTRL;
      STATUS_OFS:  reg_decode = RSF_REG_STATUS;
      PKTCNT_OFS:  reg_decode = RSF_REG_PKTCNT;
      BEATCNT_OFS: reg_decode = RSF_REG_BEATCNT;
      default:     reg_decode = RSF_REG_NONE;
    endcase
  endfunction

  // Assembly state
  rsf_state_e        state;
  logic [HALF_W-1:0] low_data;
  rsf_half_s         low_half;
  logic              low_abort;
  logic              in_packet;

  // Software-visible state
  logic              straddle_en;
  logic              clear_pulse;
  logic [WORD_W-1:0] packet_count;
  logic [WORD_W-1:0] beat_count;

  // Datapath helpers
  rsf_half_s         seg_half;
  rsf_half_s         enc_low;
  rsf_half_s         enc_up;
  rsf_flags_s        enc_flags;
  logic              enc_last;
  logic              enc_mode;
  rsf_beat_s         next_beat;
  rsf_beat_s         buf_out;
  logic              buf_in_valid;
  logic              buf_in_ready;
  logic              low_ended;
  logic              pair_ok;
  logic              seg_block;
  logic              seg_fire;
  logic              emit_lone;
  logic              emit_pair;
  logic              emit_flush;
  logic [1:0]        end_count;

  // AXI4-Lite slave state
  logic              aw_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_hold;
  logic [WORD_W-1:0] w_data;
  logic [STRB_W-1:0] w_strb;
  logic              wr_go;
  rsf_reg_e          wr_reg;
  rsf_reg_e          rd_reg;
  logic [WORD_W-1:0] rd_word;

  // A lower half that ended is only held when a straddled partner may follow
  assign low_ended = (state == RSF_HAVE_LOW) && low_half.stop;

  // Pairing needs straddling on and no abort on the lower packet
  assign pair_ok   = straddle_en && !seg_abort;

  // An aborted packet may not be the second start of a beat
  assign seg_block = low_ended && seg_last && seg_abort;

  // Segment handshake; stalls whenever the buffer is full
  assign seg_ready = ce && buf_in_ready && !seg_block;
  assign seg_fire  = seg_valid && seg_ready;

  // Without straddling a lone last half ships at once, upper half empty
  assign emit_lone  = (state == RSF_EMPTY) && seg_fire && seg_last && !pair_ok;
  assign emit_pair  = (state == RSF_HAVE_LOW) && seg_fire;
  // Held end with no partner ready: ship it rather than wait
  assign emit_flush = low_ended && ce && buf_in_ready && (!seg_valid || seg_block);
  assign buf_in_valid = emit_lone || emit_pair || emit_flush;

  // Incoming segment described as a half
  always_comb
  begin
    seg_half         = '0;
    seg_half.present = 1'b1;
    seg_half.start   = !in_packet;
    seg_half.stop    = seg_last;
    seg_half.offset  = seg_last_offset;
  end

  // Beat composition; fields follow the very halves placed on the data
  always_comb
  begin
    next_beat = '0;
    if (state == RSF_EMPTY)
    begin
      enc_low        = seg_half;
      enc_up         = '0;
      next_beat.data = {HALF_ZERO, seg_data};
      next_beat.abort = seg_abort;
    end
    else
    begin
      enc_low        = low_half;
      enc_up         = emit_pair ? seg_half : '0;
      next_beat.data = {(emit_pair ? seg_data : HALF_ZERO), low_data};
      next_beat.abort = low_abort || (emit_pair && seg_abort);
    end
    next_beat.last  = enc_last;
    next_beat.flags = enc_flags;
  end

  // A held paired lower half keeps its straddle meaning if the mode flips
  assign enc_mode = straddle_en || low_ended;

  rsf_flag_encoder u_enc (
    .straddle (enc_mode),
    .low      (enc_low),
    .up       (enc_up),
    .flags    (enc_flags),
    .last     (enc_last)
  );

  rsf_stream_buffer #(
    .WIDTH ($bits(rsf_beat_s)),
    .DEPTH (2)
  ) u_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (next_beat),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (buf_out)
  );

  // Stream outputs straight from buffer flops; bits 79:0 belong elsewhere
  assign req_data  = buf_out.data;
  assign req_last  = buf_out.last;
  assign req_abort = buf_out.abort;
  assign request_stream_sideband = {buf_out.flags, SIDEBAND_LOW_ZERO};

  // Half-beat assembly state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= RSF_EMPTY;
    end
    else if (ce)
    begin
      case (state)
        RSF_EMPTY:
        begin
          if (seg_fire && !emit_lone)
          begin
            state <= RSF_HAVE_LOW;
          end
        end
        RSF_HAVE_LOW:
        begin
          if (emit_pair || emit_flush)
          begin
            state <= RSF_EMPTY;
          end
        end
        default:
        begin
          state <= RSF_EMPTY;
        end
      endcase
    end
  end

  // Lower half holding register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      low_data  <= '0;
      low_half  <= '0;
      low_abort <= 1'b0;
    end
    else if (ce && (state == RSF_EMPTY) && seg_fire)
    begin
      low_data  <= seg_data;
      low_half  <= seg_half;
      low_abort <= seg_abort;
    end
  end

  // Packet tracking: the segment after a last one starts a packet
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      in_packet <= 1'b0;
    end
    else if (ce && seg_fire)
    begin
      in_packet <= !seg_last;
    end
  end

  // Ends in the shipped beat
  assign end_count = {1'b0, enc_flags.packet_end_flags[0]} +
                     {1'b0, enc_flags.packet_end_flags[1]};

  // Counters; a clear in the same cycle keeps that cycle's increment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      packet_count <= WORD_ZERO;
      beat_count   <= WORD_ZERO;
    end
    else if (ce)
    begin
      packet_count <= (clear_pulse ? WORD_ZERO : packet_count) +
                      (buf_in_valid ? WORD_W'(end_count) : WORD_ZERO);
      beat_count   <= (clear_pulse ? WORD_ZERO : beat_count) +
                      WORD_W'(buf_in_valid);
    end
  end

  // Write address and data are taken independently, one write at a time
  assign s_axi_awready = ce && !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_hold && !s_axi_bvalid;
  assign wr_go         = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_reg        = reg_decode(aw_addr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_hold <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_hold <= 1'b0;
      w_data <= WORD_ZERO;
      w_strb <= '0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_hold <= 1'b0;
      end
    end
  end

  // Write response; read-only registers take writes silently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else if (ce)
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == RSF_REG_NONE) ? AXI_SLVERR : AXI_OKAY;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register: straddle mode and counter clear strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      straddle_en <= CTRL_STRADDLE_RESET;
      clear_pulse <= 1'b0;
    end
    else if (ce)
    begin
      clear_pulse <= wr_go && (wr_reg == RSF_REG_CTRL) && w_strb[0] &&
                     w_data[CTRL_CLEAR_BIT];
      if (wr_go && (wr_reg == RSF_REG_CTRL) && w_strb[0])
      begin
        straddle_en <= w_data[CTRL_STRADDLE_BIT];
      end
    end
  end

  // Read data selection
  assign rd_reg = reg_decode(s_axi_araddr);
  always_comb
  begin
    rd_word = WORD_ZERO;
    case (rd_reg)
      RSF_REG_CTRL:    rd_word[CTRL_STRADDLE_BIT] = straddle_en;
      RSF_REG_STATUS:
      begin
        rd_word[STAT_HOLD_BIT]  = (state == RSF_HAVE_LOW);
        rd_word[STAT_INPKT_BIT] = in_packet;
        rd_word[STAT_OUTV_BIT]  = req_valid;
      end
      RSF_REG_PKTCNT:  rd_word = packet_count;
      RSF_REG_BEATCNT: rd_word = beat_count;
      default:         rd_word = WORD_ZERO;
    endcase
  end

  // Read channel: one read in flight, answered the cycle after it is taken
  assign s_axi_arready = ce && !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= WORD_ZERO;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (rd_reg == RSF_REG_NONE) ? AXI_SLVERR : AXI_OKAY;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: verif/rsf_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_chk
(
  // Clock and reset
  input wire logic                           aclk,
  input wire logic                           aresetn,
  // Enable and request stream
  input wire logic                           ce,
  input wire logic                           req_valid,
  input wire logic                           req_ready,
  input wire logic                           req_last,
  input wire logic                           req_abort,
  input wire logic [rsf_pkg::SIDEBAND_W-1:0] request_stream_sideband
);
  import rsf_pkg::*;
  logic [15:0] sb;
  // Boundary fields only; lower sideband belongs to other blocks
  assign sb = request_stream_sideband[95:80];
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A stalled beat must not move unless ce hides it
  sequence stalled;
    req_valid && !req_ready && ce;
  endsequence
  sequence held;
    !ce || (req_valid && $stable(request_stream_sideband));
  endsequence
  a_start_code: assert property (req_valid |-> sb[1:0] != 2'h2)
    else $error("reserved start code");
  a_end_code: assert property (req_valid |-> sb[7:6] != 2'h2)
    else $error("reserved end code");
  a_lane_code: assert property (req_valid && sb[0] |-> sb[3:2] inside {2'h0, 2'h2})
    else $error("reserved first lane code");
  a_two_starts: assert property (req_valid && sb[1] |-> sb[3:2] == LANE_0_CODE)
    else $error("first of two starts not in lane 0");
  a_second_lane: assert property (req_valid |-> sb[5:4] == (sb[1] ? 2'h2 : 2'h0))
    else $error("second lane field wrong");
  a_last_end: assert property (req_valid |-> req_last == sb[6])
    else $error("tlast disagrees with end flag");
  a_abort_alone: assert property (req_valid && req_abort |-> !sb[1])
    else $error("second start beside abort");
  a_beat_held: assert property (stalled |=> held)
    else $error("stalled beat changed");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !req_valid)
    else $error("valid after reset");
endmodule
bind rsf_framer rsf_chk u_chk (
  .aclk                    (aclk),
  .aresetn                 (aresetn),
  .ce                      (ce),
  .req_valid               (req_valid),
  .req_ready               (req_ready),
  .req_last                (req_last),
  .req_abort               (req_abort),
  .request_stream_sideband (request_stream_sideband)
);
`default_nettype wire

// File: verif/rsf_sink.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_sink
(
  // Clock and reset
  input wire logic                           aclk,
  input wire logic                           aresetn,
  // Stall mask, one bit per phase
  input wire logic [3:0]                     stall,
  // Request stream
  input wire logic                           req_valid,
  output logic                               req_ready,
  input wire logic [rsf_pkg::BEAT_W-1:0]     req_data,
  input wire logic                           req_last,
  input wire logic                           req_abort,
  input wire logic [rsf_pkg::SIDEBAND_W-1:0] request_stream_sideband
);
  logic [1:0]  phase;
  logic [33:0] got[$];
  // Rotating phase lets one mask give prompt or slow acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end
  assign req_ready = aresetn && !stall[phase];
  // Fields are read only in accepted beats
  always @(posedge aclk)
  begin
    if (aresetn && req_valid && req_ready)
      got.push_back({req_last, req_abort, req_data[263:256], req_data[7:0],
                     request_stream_sideband[95:80]});
  end
endmodule
`default_nettype wire

// File: verif/rsf_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_framer_test;
  import rsf_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, seg_valid = 0, seg_last = 0, seg_abort = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [HALF_W-1:0] seg_data = '0;
  logic [2:0] seg_last_offset = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF, stall = 4'h0;
  wire logic seg_ready, req_valid, req_ready, req_last, req_abort, s_axi_awready;
  wire logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [BEAT_W-1:0] req_data;
  wire logic [SIDEBAND_W-1:0] request_stream_sideband;
  int errors = 0, compares = 0;
  rsf_framer u_dut (.*);
  rsf_sink u_sink (.*);
  always #5 aclk = ~aclk;
  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("wrong value wait: expected handshake, seen none");
    summarize();
  endtask
  task automatic chk(input string what, input logic [33:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Write holds each channel until its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 99) hang();
    chk("write response", {32'h0, r}, {32'h0, s_axi_bresp});
    // One idle edge keeps a following call off this time step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    s_axi_araddr <= a;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    if (n == 99) hang();
    chk("read data", {2'h0, d}, {2'h0, s_axi_rdata});
    chk("read response", {32'h0, r}, {32'h0, s_axi_rresp});
    @(posedge aclk);
  endtask
  // Segments go back to back; valid stays up between calls
  task automatic seg(input logic [7:0] t, input logic l, input logic [2:0] o, input logic ab);
    int n;
    seg_valid <= 1'b1;
    seg_data <= {32{t}};
    seg_last <= l;
    seg_last_offset <= o;
    seg_abort <= ab;
    for (n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (seg_ready) break;
    end
    if (n == 99) hang();
  endtask
  task automatic idle();
    seg_valid <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic beat(input logic [15:0] f, input logic l, ab, input logic [7:0] up, lo);
    int n;
    for (n = 0; n < 99 && u_sink.got.size() == 0; n++) @(posedge aclk);
    if (n == 99) hang();
    chk("beat", {l, ab, up, lo, f}, u_sink.got.pop_front());
  endtask
  task automatic t_regs();
    rd(CTRL_OFS, 32'h0, AXI_OKAY);
    rd(8'h10, 32'h0, AXI_SLVERR);
    $display("test registers done");
  endtask
  // Straddle off, receiver stalls every other cycle
  task automatic t_plain();
    stall <= 4'h5;
    seg(8'h10, 1'b0, 3'h0, 1'b0);
    seg(8'h11, 1'b1, 3'h3, 1'b0);
    seg(8'h20, 1'b1, 3'h5, 1'b0);
    seg(8'h30, 1'b0, 3'h0, 1'b0);
    seg(8'h31, 1'b0, 3'h0, 1'b0);
    seg(8'h32, 1'b1, 3'h7, 1'b0);
    idle();
    beat(16'h0B41, 1'b1, 1'b0, 8'h11, 8'h10);
    beat(16'h0541, 1'b1, 1'b0, 8'h00, 8'h20);
    beat(16'h0001, 1'b0, 1'b0, 8'h31, 8'h30);
    beat(16'h0740, 1'b1, 1'b0, 8'h00, 8'h32);
    rd(PKTCNT_OFS, 32'h3, AXI_OKAY);
    rd(BEATCNT_OFS, 32'h4, AXI_OKAY);
    $display("test plain done");
  endtask
  // Straddle on, slow receiver, abort refused as second start
  task automatic t_straddle();
    stall <= 4'h3;
    wr(CTRL_OFS, 32'h1, AXI_OKAY);
    rd(CTRL_OFS, 32'h1, AXI_OKAY);
    seg(8'h40, 1'b1, 3'h2, 1'b0);
    seg(8'h41, 1'b1, 3'h5, 1'b0);
    seg(8'h50, 1'b0, 3'h0, 1'b0);
    seg(8'h51, 1'b1, 3'h1, 1'b0);
    seg(8'h60, 1'b1, 3'h0, 1'b0);
    seg(8'h61, 1'b0, 3'h0, 1'b0);
    seg(8'h62, 1'b1, 3'h4, 1'b0);
    seg(8'h63, 1'b1, 3'h6, 1'b0);
    seg(8'h70, 1'b1, 3'h3, 1'b0);
    seg(8'h71, 1'b1, 3'h2, 1'b1);
    idle();
    beat(16'hD2E3, 1'b1, 1'b0, 8'h41, 8'h40);
    beat(16'h0941, 1'b1, 1'b0, 8'h51, 8'h50);
    beat(16'h0063, 1'b1, 1'b0, 8'h61, 8'h60);
    beat(16'hE4C9, 1'b1, 1'b0, 8'h63, 8'h62);
    beat(16'h0341, 1'b1, 1'b0, 8'h00, 8'h70);
    beat(16'h0241, 1'b1, 1'b1, 8'h00, 8'h71);
    $display("test straddle done");
  endtask
  // Enable low hides a pending beat; status, counter clear, bad write
  task automatic t_misc();
    stall <= 4'hF;
    seg(8'h80, 1'b1, 3'h1, 1'b0);
    idle();
    ce <= 1'b0;
    @(posedge aclk);
    chk("frozen handshakes", 34'h0, {32'h0, req_valid, seg_ready});
    ce <= 1'b1;
    rd(STATUS_OFS, 32'h4, AXI_OKAY);
    stall <= 4'h0;
    beat(16'h0141, 1'b1, 1'b0, 8'h00, 8'h80);
    wr(CTRL_OFS, 32'h3, AXI_OKAY);
    rd(PKTCNT_OFS, 32'h0, AXI_OKAY);
    rd(BEATCNT_OFS, 32'h0, AXI_OKAY);
    wr(8'h10, 32'h0, AXI_SLVERR);
    $display("test misc done");
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_plain();
    t_straddle();
    t_misc();
    summarize();
  end
endmodule
`default_nettype wire
